//--- design/qnio_pkg.sv
/*
  Constants shared by the three-port nibble I/O block: operand fields,
  reset values, register map offsets and the serial pulse width.
  Assumes a single 100 MHz clock domain and an AXI4-Lite master.
*/
package qnio_pkg;
  localparam int         NIB        = 4;
  localparam int         PULL_BIT   = 4;       // operand bit of pull flag
  localparam logic [4:0] DIR_RST    = 5'h10;   // all input, pull on
  localparam logic [3:0] LAT_RST    = 4'h0;
  localparam logic [1:0] HOLD_RST   = 2'h0;    // hold off at reset
  localparam int         PULSE_NS   = 20;
  localparam int         CLK_NS     = 10;
  localparam logic [3:0] PULSE_CYC  = 4'((PULSE_NS + CLK_NS - 1) / CLK_NS);
  // register byte offsets
  localparam logic [7:0] A_LAT      = 8'h00;   // write: latch, read: port
  localparam logic [7:0] B_LAT      = 8'h04;
  localparam logic [7:0] C_LAT      = 8'h08;
  localparam logic [7:0] A_DIR      = 8'h0c;   // direction-set operand
  localparam logic [7:0] B_DIR      = 8'h10;
  localparam logic [7:0] C_DIR      = 8'h14;
  localparam logic [7:0] A_SER      = 8'h18;   // [2:0] data, [3] pulse
  localparam logic [7:0] STATUS     = 8'h1c;   // pull/hold state
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLV   = 2'h2;
endpackage

//--- design/qnio_ports.sv
/*
  Three nibble GPIO ports with per-bit direction, output latches,
  pull-low enables, port C hold device and port A serial write mode.
  Assumes pad logic resolves pins from out/oe and reports pin levels.
*/
`timescale 1ns/100ps
`default_nettype none
module qnio_ports
  import qnio_pkg::*;
#(
  parameter logic [3:0] ALT_A   = 4'h0, // build-time alternate pins
  parameter logic [3:0] ALT_B   = 4'h0,
  parameter logic [3:0] ALT_C   = 4'h0,
  parameter bit         PULL_A  = 1'b1,
  parameter bit         PULL_B  = 1'b1,
  parameter bit         PULL_C  = 1'b1,
  parameter bit         HOLD_C  = 1'b1
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pins
  input  wire logic [3:0]  port_a_in,
  output logic [3:0]       port_a_out,
  output logic [3:0]       port_a_oe,
  output logic [3:0]       port_a_pull_en,
  input  wire logic [3:0]  port_b_in,
  output logic [3:0]       port_b_out,
  output logic [3:0]       port_b_oe,
  output logic [3:0]       port_b_pull_en,
  input  wire logic [3:0]  port_c_in,
  output logic [3:0]       port_c_out,
  output logic [3:0]       port_c_oe,
  output logic [3:0]       port_c_pull_en,
  output logic [3:0]       port_c_hold_en
);

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [4:0]  dir_a_q, dir_a_d, dir_b_q, dir_b_d, dir_c_q, dir_c_d;
  logic [3:0]  lat_a_q, lat_a_d, lat_b_q, lat_b_d, lat_c_q, lat_c_d;
  logic [1:0]  hold_q, hold_d;      // [1] set by any port c direction-set write, [0] hold enable
  logic [3:0]  pulse_q, pulse_d;
  logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0]  ws_q, ws_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic [3:0]  oa_q, oa_d, ob_q, ob_d, oc_q, oc_d;
  logic [3:0]  ea_q, ea_d, eb_q, eb_d, ec_q, ec_d;
  logic [3:0]  pa_q, pa_d, pb_q, pb_d, pc_q, pc_d, hc_q, hc_d;
  logic        wr_go;
  logic [3:0]  rd_a, rd_b, rd_c;
  logic        hold_ok;

  // hold device exists only together with the resistor
  assign hold_ok = HOLD_C & PULL_C;

  ////////////////////////////////////////////////////////////////////////
  // read-back: latch for output bits, pin for input bits, 0 on alt pins
  assign rd_a = ~ALT_A & ((dir_a_q[3:0] & lat_a_q) |
                          (~dir_a_q[3:0] & port_a_in));
  assign rd_b = ~ALT_B & ((dir_b_q[3:0] & lat_b_q) |
                          (~dir_b_q[3:0] & port_b_in));
  assign rd_c = ~ALT_C & ((dir_c_q[3:0] & lat_c_q) |
                          (~dir_c_q[3:0] & port_c_in));
  assign wr_go = aw_q & w_q & ~bv_q;

  ////////////////////////////////////////////////////////////////////////
  // next-state: bus handshakes, port registers and pin drive
  always_comb begin
    aw_d = aw_q;  awa_d = awa_q;  w_d = w_q;  wd_d = wd_q;  ws_d = ws_q;
    bv_d = bv_q;  br_d = br_q;  rv_d = rv_q;  rd_d = rd_q;  rr_d = rr_q;
    dir_a_d = dir_a_q;  dir_b_d = dir_b_q;  dir_c_d = dir_c_q;
    lat_a_d = lat_a_q;  lat_b_d = lat_b_q;  lat_c_d = lat_c_q;
    hold_d = hold_q;
    pulse_d = (pulse_q != 4'h0) ? pulse_q - 4'h1 : 4'h0;
    if (s_axi_awvalid && !aw_q) begin
      aw_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q) begin
      w_d = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      br_d = RESP_OKAY;
      if (ws_q[0]) begin
        case (awa_q)
          A_LAT: lat_a_d = wd_q[3:0];
          B_LAT: lat_b_d = wd_q[3:0];
          C_LAT: lat_c_d = wd_q[3:0];
          A_DIR: dir_a_d = wd_q[4:0];
          B_DIR: dir_b_d = wd_q[4:0];
          C_DIR: begin
            dir_c_d = wd_q[4:0];
            hold_d = {1'b1, hold_ok};   // 10h and 0h both hold on
          end
          A_SER: begin
            lat_a_d = {1'b0, wd_q[2:0]};
            pulse_d = PULSE_CYC;
          end
          STATUS: ;
          default: br_d = RESP_SLV;
        endcase
      end else if (awa_q > STATUS || awa_q[1:0] != 2'h0) begin
        br_d = RESP_SLV;
      end
    end
    if (bv_q && s_axi_bready) bv_d = 1'b0;
    if (rv_q && s_axi_rready) rv_d = 1'b0;
    if (s_axi_arvalid && !rv_q) begin
      rv_d = 1'b1;
      rr_d = RESP_OKAY;
      rd_d = 32'h0;
      case (s_axi_araddr)
        A_LAT:  rd_d[3:0] = rd_a;
        B_LAT:  rd_d[3:0] = rd_b;
        C_LAT:  rd_d[3:0] = rd_c;
        A_DIR:  rd_d[4:0] = dir_a_q;
        B_DIR:  rd_d[4:0] = dir_b_q;
        C_DIR:  rd_d[4:0] = dir_c_q;
        A_SER:  rd_d[3:0] = lat_a_q;
        STATUS: rd_d[15:0] = {pc_q, hc_q, pb_q, pa_q};
        default: rr_d = RESP_SLV;
      endcase
    end
    // pin drive from latch on output bits only, port a bit 3 also from the serial pulse
    ea_d = dir_a_d[3:0] & ~ALT_A;
    eb_d = dir_b_d[3:0] & ~ALT_B;
    ec_d = dir_c_d[3:0] & ~ALT_C;
    oa_d = lat_a_d & ea_d;
    oa_d[3] = ea_d[3] & (lat_a_d[3] | (pulse_d != 4'h0));
    ob_d = lat_b_d & eb_d;
    oc_d = lat_c_d & ec_d;
    // pull devices only on input bits
    pa_d = {NIB{PULL_A & dir_a_d[PULL_BIT]}} & ~ea_d & ~ALT_A;
    pb_d = {NIB{PULL_B & dir_b_d[PULL_BIT]}} & ~eb_d & ~ALT_B;
    pc_d = {NIB{PULL_C & dir_c_d[PULL_BIT]}} & ~ec_d & ~ALT_C;
    hc_d = {NIB{hold_ok & hold_d[0]}} & ~ec_d & ~ALT_C;
  end

  ////////////////////////////////////////////////////////////////////////
  // registers; reset leaves every bit input, resistor on, hold off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_a_q <= DIR_RST;  dir_b_q <= DIR_RST;  dir_c_q <= DIR_RST;
      lat_a_q <= LAT_RST;  lat_b_q <= LAT_RST;  lat_c_q <= LAT_RST;
      hold_q <= HOLD_RST;
      pulse_q <= 4'h0;
      aw_q <= 1'b0;  w_q <= 1'b0;  bv_q <= 1'b0;  rv_q <= 1'b0;
      awa_q <= 8'h0;  wd_q <= 32'h0;  ws_q <= 4'h0;  rd_q <= 32'h0;
      br_q <= RESP_OKAY;  rr_q <= RESP_OKAY;
      oa_q <= 4'h0;  ob_q <= 4'h0;  oc_q <= 4'h0;
      ea_q <= 4'h0;  eb_q <= 4'h0;  ec_q <= 4'h0;
      pa_q <= 4'h0;  pb_q <= 4'h0;  pc_q <= 4'h0;  hc_q <= 4'h0;
    end else begin
      dir_a_q <= dir_a_d;  dir_b_q <= dir_b_d;  dir_c_q <= dir_c_d;
      lat_a_q <= lat_a_d;  lat_b_q <= lat_b_d;  lat_c_q <= lat_c_d;
      hold_q <= hold_d;  pulse_q <= pulse_d;
      aw_q <= aw_d;  w_q <= w_d;  bv_q <= bv_d;  rv_q <= rv_d;
      awa_q <= awa_d;  wd_q <= wd_d;  ws_q <= ws_d;  rd_q <= rd_d;
      br_q <= br_d;  rr_q <= rr_d;
      oa_q <= oa_d;  ob_q <= ob_d;  oc_q <= oc_d;
      ea_q <= ea_d;  eb_q <= eb_d;  ec_q <= ec_d;
      pa_q <= pa_d;  pb_q <= pb_d;  pc_q <= pc_d;  hc_q <= hc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops; alt pins for B and C stay idle
  // here, the shared functions drive them from outside
  assign s_axi_awready  = ~aw_q;
  assign s_axi_wready   = ~w_q;
  assign s_axi_bvalid   = bv_q;
  assign s_axi_bresp    = br_q;
  assign s_axi_arready  = ~rv_q;
  assign s_axi_rvalid   = rv_q;
  assign s_axi_rdata    = rd_q;
  assign s_axi_rresp    = rr_q;
  assign port_a_out     = oa_q;
  assign port_a_oe      = ea_q;
  assign port_a_pull_en = pa_q;
  assign port_b_out     = ob_q;
  assign port_b_oe      = eb_q;
  assign port_b_pull_en = pb_q;
  assign port_c_out     = oc_q;
  assign port_c_oe      = ec_q;
  assign port_c_pull_en = pc_q;
  assign port_c_hold_en = hc_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence ser_wr_s;
    wr_go && ws_q[0] && awa_q == A_SER;
  endsequence

  // port c direction-set write being executed
  sequence c_dir_wr_s;
    wr_go && ws_q[0] && awa_q == C_DIR;
  endsequence

  // port b latch write being executed
  sequence b_lat_wr_s;
    wr_go && ws_q[0] && awa_q == B_LAT;
  endsequence

  // read of port c being accepted
  sequence c_rd_s;
    s_axi_arvalid && !rv_q && s_axi_araddr == C_LAT;
  endsequence

  // reset released at this edge
  sequence rst_end_s;
    !aresetn ##1 aresetn;
  endsequence

  reset_input_a: assert property (@(posedge aclk)
    !aresetn |=> port_a_oe == 4'h0 && port_b_oe == 4'h0
                 && port_c_oe == 4'h0)
    else $error("port not input after reset");
  drive_mask_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (port_b_out & ~port_b_oe) == 4'h0)
    else $error("port b drives an input bit");
  readback_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && !rv_q && s_axi_araddr == B_LAT |=>
    s_axi_rdata[3:0] == $past(rd_b))
    else $error("port b read value wrong");
  pull_out_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (port_c_oe & (port_c_pull_en | port_c_hold_en)) == 4'h0)
    else $error("port c pull active on output");
  hold_dflt_a: assert property (@(posedge aclk)
    !aresetn |=> port_c_hold_en == 4'h0)
    else $error("hold device on after reset");
  serial_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ser_wr_s ##1 port_a_oe == 4'hf |->
    ##1 port_a_out[3] && port_a_out[2:0] == $past(wd_q[2:0], 2))
    else $error("serial write output wrong");
  alt_off_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (port_a_oe & ALT_A) == 4'h0)
    else $error("alternate pin driven");
  dir_load_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_go && ws_q[0] && awa_q == A_DIR |=> ##1
    port_a_oe == ($past(wd_q[3:0], 2) & ~ALT_A))
    else $error("direction not applied");
  // no drive on input bits of ports a and c
  drive_ac_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (port_a_out & ~port_a_oe) == 4'h0 && (port_c_out & ~port_c_oe) == 4'h0)
    else $error("port a or c drives an input bit");
  // alternate pins of ports b and c are neither driven nor pulled
  alt_bc_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ((port_b_oe | port_b_pull_en) & ALT_B) == 4'h0
    && ((port_c_oe | port_c_pull_en | port_c_hold_en) & ALT_C) == 4'h0)
    else $error("alternate pin driven or pulled");
  // pull-low of ports a and b only on input bits
  pull_in_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (port_a_oe & port_a_pull_en) == 4'h0
    && (port_b_oe & port_b_pull_en) == 4'h0)
    else $error("pull-low active on an output bit");
  // port c resistor on and hold off on every usable bit once reset ends
  pull_dflt_a: assert property (
    @(posedge aclk)
    rst_end_s |=> port_c_pull_en == ({NIB{PULL_C}} & ~ALT_C)
                  && port_c_hold_en == 4'h0)
    else $error("port c pull defaults wrong");
  // any port c direction-set write turns the hold device on
  c_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    c_dir_wr_s |=> ##1
    port_c_hold_en == ({NIB{HOLD_C & PULL_C}} & ~port_c_oe & ~ALT_C))
    else $error("port c hold device setting wrong");
  // port c resistor follows the pull flag of the operand
  c_pull_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    c_dir_wr_s |=> ##1
    port_c_pull_en == ({NIB{PULL_C & $past(wd_q[PULL_BIT], 2)}}
                       & ~port_c_oe & ~ALT_C))
    else $error("port c resistor setting wrong");
  // port b latch reaches only the pins set as outputs
  b_lat_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    b_lat_wr_s |=> ##1 port_b_out == ($past(wd_q[3:0], 2) & port_b_oe))
    else $error("port b latch not driven");
  // port c read gives latch on output bits, pin on input bits
  read_c_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    c_rd_s |=> s_axi_rdata[3:0] == ($past(port_c_out)
               | ($past(port_c_in) & ~$past(port_c_oe) & ~ALT_C)))
    else $error("port c read value wrong");
  // serial clock bit stays high for the whole two-cycle pulse
  pulse_len_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ser_wr_s ##1 port_a_oe[3] |-> port_a_out[3] [*2])
    else $error("serial pulse too short");
endmodule
`default_nettype wire

//--- tb/qnio_board.sv
/*
  Board side of one nibble port: works out the pin level from the
  block's drive, an external driver and the pull-low devices.
  Assumes one instance per port, on the block's clock.
*/
`timescale 1ns/100ps
`default_nettype none
module qnio_board (
  // clock
  input  wire logic       aclk,
  // block side
  input  wire logic [3:0] drv,
  input  wire logic [3:0] oe,
  input  wire logic [3:0] pull,
  // external driver
  input  wire logic [3:0] ext_v,
  input  wire logic [3:0] ext_en,
  // resolved pin level
  output logic [3:0]      pin
);
  logic [3:0] last_q = 4'h0;
  // remember the level so that a floating pin keeps wandering
  always @(posedge aclk) last_q <= pin;
  // block drive wins, then the board, then pull-low, else float
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      pin[b] = oe[b] ? drv[b] : ext_en[b] ? ext_v[b] :
               pull[b] ? 1'b0 : ~last_q[b];
    end
  end
endmodule
`default_nettype wire

//--- tb/qnio_ports_tb.sv
/*
  Self-checking bench: axi4-lite tasks and port scenarios.
  Assumes qnio_board stands on each port's pins.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module qnio_ports_tb import qnio_pkg::*;;
  logic        aclk, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_v;
  logic [3:0]  s_axi_wstrb = 4'h0, port_c_hold_en;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0]  p_in[3], p_out[3], p_oe[3], p_pull[3];
  logic [3:0]  ext_v[3] = '{default: 4'h0}, ext_en[3] = '{default: 4'h0};
  logic [31:0] c_dir[3] = '{32'h10, 32'h0, 32'h19};
  logic [7:0]  c_exp[3] = '{8'hff, 8'h0f, 8'h66};
  // port b bit 3 is alternate: never pulled, read as zero
  logic [3:0]  pl_rst[3] = '{4'hf, 4'h7, 4'hf};
  logic [3:0]  pl_exp[3] = '{4'hc, 4'h4, 4'hc};
  logic [31:0] rb_exp[3] = '{32'h9, 32'h1, 32'h9};
  int          failures = 0, cmp_count = 0, wid;
  // device under test
  qnio_ports #(.ALT_B(4'h8)) // port b bit 3 built for an alternate use
  qnio_ports_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .port_a_in(p_in[0]), .port_a_out(p_out[0]), .port_a_oe(p_oe[0]),
    .port_a_pull_en(p_pull[0]), .port_b_in(p_in[1]),
    .port_b_out(p_out[1]), .port_b_oe(p_oe[1]),
    .port_b_pull_en(p_pull[1]), .port_c_in(p_in[2]),
    .port_c_out(p_out[2]), .port_c_oe(p_oe[2]),
    .port_c_pull_en(p_pull[2]), .port_c_hold_en);
  // board model per port, the hold device acting as a pull-low
  for (genvar g = 0; g < 3; g++) begin : g_pad
    qnio_board qnio_board_i (.aclk, .drv(p_out[g]), .oe(p_oe[g]),
      .pull(p_pull[g] | (g == 2 ? port_c_hold_en : 4'h0)),
      .ext_v(ext_v[g]), .ext_en(ext_en[g]), .pin(p_in[g]));
  end
  // 100 mhz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic ah, wh, bh;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(negedge aclk);
      ah  = s_axi_awvalid && s_axi_awready;
      wh  = s_axi_wvalid && s_axi_wready;
      bh  = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end while (bh !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  // read: data and response taken at the falling edge that sees rvalid
  task automatic rd(input logic [7:0] a);
    logic ah, rh;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge aclk);
      ah   = s_axi_arvalid && s_axi_arready;
      rh   = s_axi_rvalid;
      rd_v = s_axi_rdata;
      rsp  = s_axi_rresp;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 1'b0;
    end while (rh !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  // verdict and end of run
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(negedge aclk);
    for (int i = 0; i < 3; i++) begin
      `CHK(p_oe[i], 4'h0)
      `CHK(p_pull[i], pl_rst[i])
    end
    `CHK(port_c_hold_en, 4'h0)
    for (int i = 0; i < 3; i++) begin
      wr(8'(4 * i), 32'h5, 4'hf); // latch before output mode
      ext_v[i]  <= 4'ha;
      ext_en[i] <= 4'hf;
      wr(8'(8'h0c + 4 * i), 32'h13, 4'hf); // low bits out, pull on
      repeat (3) @(negedge aclk);
      `CHK(p_oe[i], 4'h3)
      `CHK(p_out[i], 4'h1)
      `CHK(p_pull[i], pl_exp[i])
      rd(8'(4 * i));
      `CHK(rd_v, rb_exp[i])
    end
    wr(B_DIR, 32'h1f, 4'hf); // all out, bit 3 stays alternate
    repeat (2) @(negedge aclk);
    `CHK(p_oe[1], 4'h7)
    wr(A_LAT, 32'hf, 4'h0); // strobe off, no write
    `CHK(rsp, RESP_OKAY)
    rd(A_LAT);
    `CHK(rd_v, 32'h9)
    rd(8'h20);
    `CHK(rsp, RESP_SLV)
    // port c pull and hold settings, last one with two output bits
    foreach (c_dir[k]) begin
      wr(C_DIR, c_dir[k], 4'hf);
      repeat (3) @(negedge aclk);
      `CHK({p_pull[2], port_c_hold_en}, c_exp[k])
    end
    wr(A_DIR, 32'h0f, 4'hf); // all outputs before serial
    wid = 0;
    fork
      wr(A_SER, 32'h5, 4'hf); // bits 2:0 loaded from data 5, bit 3 pulsed
      repeat (20) begin
        @(negedge aclk);
        wid += int'(p_out[0][3] === 1'b1);
      end
    join
    `CHK(wid, int'(PULSE_CYC))
    `CHK(p_out[0][2:0], 3'h5)
    `CHK(p_out[0][1], 1'b0) // bit 1 held steady
    tally_and_finish();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (3000) @(posedge aclk);
    failures++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
